// ===== include/cftail_consts.vh
// Constants for the CPU flags register and tail-opcode execute block
`ifndef CFTAIL_CONSTS_VH
`define CFTAIL_CONSTS_VH
// Flag bit positions in the flags register
`define CFT_FLAG_OUT 7
`define CFT_FLAG_NULL 6
`define CFT_FLAG_TOP 5
`define CFT_FLAG_LIMIT 4
`define CFT_FLAG_MINUS 3
`define CFT_FLAG_NIBBLE 2
`define CFT_FLAG_USER2 1
`define CFT_FLAG_USER1 0
// Reset value of the six status bits
`define CFT_STATUS_RST 6'h00
// Opcodes (first byte; the two LSR codes are the second byte after the prefix)
`define CFT_OP_SET_CARRY 8'hDF
`define CFT_OP_ASR_R 8'hD0
`define CFT_OP_ASR_IR 8'hD1
`define CFT_OP_PREFIX 8'h1F
`define CFT_OP_LSR_R 8'hC0
`define CFT_OP_LSR_IR 8'hC1
`define CFT_OP_BANK 8'h01
`define CFT_OP_STOP 8'h6F
`define CFT_OP_SWAP_R 8'hF0
`define CFT_OP_SWAP_IR 8'hF1
`define CFT_OP_TRAP 8'hF2
`define CFT_OP_WDOG 8'h5F
// Opcode groups by upper nibble; low nibble 2..7 register, 8..9 extended
`define CFT_HI_SUB 4'h2
`define CFT_HI_CMASK 4'h6
`define CFT_HI_MASK 4'h7
`define CFT_HI_XOR 4'hB
`define CFT_LO_REG_MIN 4'h2
`define CFT_LO_REG_MAX 4'h7
`define CFT_LO_EXT_MIN 4'h8
`define CFT_LO_EXT_MAX 4'h9
// Trap stack steps
`define CFT_SP_PC_STEP 8'h02
`define CFT_SP_FLAG_STEP 8'h01
// Instruction cycles taken by the trap
`define CFT_TRAP_CYCLES 3'd6
`endif

// ===== rtl/cftail_exec.v
// Flags register and execute logic for the tail group of CPU opcodes
// Functional notes
// - Six status bits track latest ALU result
// - Jumps test carry, overflow, zero, sign only
// - Nibble-carry and minus bits not jump-testable
// - Arithmetic never touches user bits one, two
// - User bits not reset, start undefined
// - Interrupt and traps push flags to stack
// - Interrupt return reloads flags from stack
// - Trap: SP-2 PC, SP-3 flags, six cycles
// - Subtract writes dst-src, minus bit forced one
// - Xor writes result, clears limit, keeps carry
// - Arithmetic shift right keeps bit seven
// - Logic shift right, prefixed, clears sign bit
// - Star follows result, dash keeps, X undefined
`timescale 1ns/100ps
`include "cftail_consts.vh"
`default_nettype none
module cftail_exec
(
    // Clock and reset
    input wire clk_i,
    input wire nrst_i,
    // Instruction issue
    input wire exec_i,
    input wire [7:0] opcode_i,
    input wire [7:0] opcode2_i,
    input wire [7:0] dst_i,
    input wire [7:0] src_i,
    input wire [7:0] vector_pc_i,
    input wire [15:0] pc_i,
    input wire [7:0] sp_i,
    // Flags events
    input wire irq_entry_i,
    input wire illegal_trap_i,
    input wire interrupt_return_op_i,
    input wire [7:0] interrupt_return_op_flags_i,
    input wire user_set_i,
    input wire [7:0] user_val_i,
    // Jump condition select
    input wire [1:0] cond_sel_i,
    // Results
    output reg dst_we_o,
    output reg [7:0] dst_data_o,
    output reg bank_we_o,
    output reg [7:0] bank_data_o,
    output reg stop_o,
    output reg wdog_refresh_o,
    // Stack writes
    output reg stack_we_o,
    output reg [7:0] stack_addr_o,
    output reg [7:0] stack_data_o,
    output reg sp_we_o,
    output reg [7:0] sp_data_o,
    output reg pc_we_o,
    output reg [15:0] pc_data_o,
    // Status
    output wire busy_o,
    output wire [7:0] flags_o,
    output wire cond_o
);

// Trap sequencer states
localparam [3:0] ST_IDLE = 4'b0001;
localparam [3:0] ST_PCLO = 4'b0010;
localparam [3:0] ST_FLAG = 4'b0100;
localparam [3:0] ST_WAIT = 4'b1000;

reg [5:0] status_q; // Status bits c z s v d h
reg [1:0] user_q; // User bits, no reset
reg [5:0] status_d; // Next status bits
reg [3:0] state_q; // Trap sequencer state
reg [2:0] cnt_q; // Trap cycle counter
reg [15:0] pc_save_q; // PC captured at trap
reg [7:0] sp_q; // Working stack pointer
reg [7:0] vec_q; // Trap vector
reg [7:0] res; // ALU result
reg wr; // Result writes destination
reg [8:0] diff; // Subtract with borrow
reg [4:0] ndiff; // Nibble subtract
wire [3:0] hi = opcode_i[7:4]; // Group nibble
wire [3:0] lo = opcode_i[3:0]; // Form nibble
wire grp_ok = (lo >= `CFT_LO_REG_MIN && lo <= `CFT_LO_REG_MAX) ||
              (lo >= `CFT_LO_EXT_MIN && lo <= `CFT_LO_EXT_MAX);
wire issue = exec_i && (state_q == ST_IDLE);
wire trap_go = issue && (opcode_i == `CFT_OP_TRAP);
wire push_go = trap_go || irq_entry_i || illegal_trap_i;

// Flags word: status bits over user bits
assign flags_o = {status_q, user_q[1], user_q[0]};
assign busy_o = (state_q != ST_IDLE);

// Jump condition mux: only carry, zero, sign, overflow reachable
assign cond_o = (cond_sel_i == 2'h0) ? status_q[5] :
                (cond_sel_i == 2'h1) ? status_q[4] :
                (cond_sel_i == 2'h2) ? status_q[3] : status_q[2];

// Decode and compute result and next status
always @*
begin
    status_d = status_q;
    res = dst_i;
    wr = 1'b0;
    diff = {1'b0, dst_i} - {1'b0, src_i};
    ndiff = {1'b0, dst_i[3:0]} - {1'b0, src_i[3:0]};
    if (issue)
    begin
        if (opcode_i == `CFT_OP_SET_CARRY)
        begin
            status_d[5] = 1'b1;
        end
        else if (opcode_i == `CFT_OP_ASR_R || opcode_i == `CFT_OP_ASR_IR)
        begin
            res = {dst_i[7], dst_i[7:1]};
            wr = 1'b1;
            status_d[5] = dst_i[0];
            status_d[4] = (res == 8'h00);
            status_d[3] = res[7];
            status_d[2] = 1'b0;
        end
        else if (opcode_i == `CFT_OP_PREFIX &&
                 (opcode2_i == `CFT_OP_LSR_R || opcode2_i == `CFT_OP_LSR_IR))
        begin
            res = {1'b0, dst_i[7:1]};
            wr = 1'b1;
            status_d[5] = dst_i[0];
            status_d[4] = (res == 8'h00);
            status_d[3] = 1'b0;
            status_d[2] = 1'b0; // Overflow forced to zero, sign is zero
        end
        else if (opcode_i == `CFT_OP_SWAP_R || opcode_i == `CFT_OP_SWAP_IR)
        begin
            res = {dst_i[3:0], dst_i[7:4]};
            wr = 1'b1;
            status_d[4] = (res == 8'h00);
            status_d[3] = res[7]; // Carry and limit left as they were
        end
        else if (hi == `CFT_HI_SUB && grp_ok)
        begin
            res = diff[7:0];
            wr = 1'b1;
            status_d[5] = diff[8];
            status_d[4] = (res == 8'h00);
            status_d[3] = res[7];
            status_d[2] = (dst_i[7] ^ src_i[7]) & (dst_i[7] ^ res[7]);
            status_d[1] = 1'b1;
            status_d[0] = ndiff[4];
        end
        else if ((hi == `CFT_HI_XOR || hi == `CFT_HI_MASK || hi == `CFT_HI_CMASK) && grp_ok)
        begin
            if (hi == `CFT_HI_XOR)
            begin
                res = dst_i ^ src_i;
                wr = 1'b1;
            end
            else if (hi == `CFT_HI_MASK)
                res = dst_i & src_i;
            else
                res = ~dst_i & src_i;
            status_d[4] = (res == 8'h00);
            status_d[3] = res[7];
            status_d[2] = 1'b0;
        end
    end
end

// Flags register; six status bits reset, user bits hold
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
        status_q <= `CFT_STATUS_RST;
    else if (interrupt_return_op_i)
        status_q <= interrupt_return_op_flags_i[7:2];
    else
        status_q <= status_d;
end

// User bits: written only explicitly or by return, never reset
always @(posedge clk_i)
begin
    if (interrupt_return_op_i)
        user_q <= interrupt_return_op_flags_i[1:0];
    else if (user_set_i)
        user_q <= user_val_i[1:0];
end

// Result strobes for single-step opcodes
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        dst_we_o <= 1'b0;
        dst_data_o <= 8'h00;
        bank_we_o <= 1'b0;
        bank_data_o <= 8'h00;
        stop_o <= 1'b0;
        wdog_refresh_o <= 1'b0;
    end
    else
    begin
        dst_we_o <= wr;
        dst_data_o <= res;
        bank_we_o <= issue && (opcode_i == `CFT_OP_BANK);
        bank_data_o <= src_i;
        stop_o <= issue && (opcode_i == `CFT_OP_STOP);
        wdog_refresh_o <= issue && (opcode_i == `CFT_OP_WDOG);
    end
end

// Flag push at SP-1; trap sequence: PC word at SP-2, flags at SP-3
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        state_q <= ST_IDLE;
        cnt_q <= 3'd0;
        pc_save_q <= 16'h0000;
        sp_q <= 8'h00;
        vec_q <= 8'h00;
        stack_we_o <= 1'b0;
        stack_addr_o <= 8'h00;
        stack_data_o <= 8'h00;
        sp_we_o <= 1'b0;
        sp_data_o <= 8'h00;
        pc_we_o <= 1'b0;
        pc_data_o <= 16'h0000;
    end
    else
    begin
        stack_we_o <= 1'b0;
        sp_we_o <= 1'b0;
        pc_we_o <= 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (trap_go)
                begin
                    // High PC byte at SP-2+1, low at SP-2
                    sp_q <= sp_i - `CFT_SP_PC_STEP;
                    pc_save_q <= pc_i;
                    vec_q <= vector_pc_i;
                    stack_we_o <= 1'b1;
                    stack_addr_o <= sp_i - `CFT_SP_FLAG_STEP;
                    stack_data_o <= pc_i[15:8];
                    cnt_q <= 3'd1;
                    state_q <= ST_PCLO;
                end
                else if (push_go)
                begin
                    stack_we_o <= 1'b1;
                    stack_addr_o <= sp_i - `CFT_SP_FLAG_STEP;
                    stack_data_o <= flags_o;
                    sp_we_o <= 1'b1;
                    sp_data_o <= sp_i - `CFT_SP_FLAG_STEP;
                end
            end
            ST_PCLO:
            begin
                stack_we_o <= 1'b1;
                stack_addr_o <= sp_q;
                stack_data_o <= pc_save_q[7:0];
                cnt_q <= cnt_q + 3'd1;
                state_q <= ST_FLAG;
            end
            ST_FLAG:
            begin
                stack_we_o <= 1'b1;
                stack_addr_o <= sp_q - `CFT_SP_FLAG_STEP;
                stack_data_o <= flags_o;
                sp_we_o <= 1'b1;
                sp_data_o <= sp_q - `CFT_SP_FLAG_STEP;
                cnt_q <= cnt_q + 3'd1;
                state_q <= ST_WAIT;
            end
            ST_WAIT:
            begin
                cnt_q <= cnt_q + 3'd1;
                if (cnt_q == `CFT_TRAP_CYCLES - 3'd1)
                begin
                    pc_we_o <= 1'b1;
                    pc_data_o <= {8'h00, vec_q};
                    state_q <= ST_IDLE;
                end
            end
            default:
                state_q <= ST_IDLE;
        endcase
    end
end

endmodule
`default_nettype wire

// ===== testbench/cftail_exec_monitor.sv
// Port-level checker for the flags and tail-opcode execute block
`timescale 1ns/100ps
`default_nettype none
module cftail_exec_monitor
(
    // Clock and reset
    input wire clk_i,
    input wire nrst_i,
    // Issue and events
    input wire exec_i,
    input wire [7:0] opcode_i,
    input wire [7:0] dst_i,
    input wire [7:0] src_i,
    input wire [7:0] vector_pc_i,
    input wire [15:0] pc_i,
    input wire [7:0] sp_i,
    input wire irq_entry_i,
    input wire illegal_trap_i,
    input wire interrupt_return_op_i,
    input wire [7:0] interrupt_return_op_flags_i,
    input wire user_set_i,
    input wire [1:0] cond_sel_i,
    // Results
    input wire dst_we_o,
    input wire [7:0] dst_data_o,
    input wire stop_o,
    input wire wdog_refresh_o,
    input wire stack_we_o,
    input wire [7:0] stack_addr_o,
    input wire [7:0] stack_data_o,
    input wire sp_we_o,
    input wire [7:0] sp_data_o,
    input wire pc_we_o,
    input wire [15:0] pc_data_o,
    input wire busy_o,
    input wire [7:0] flags_o,
    input wire cond_o
);
    // Accepted issue and opcode group decode
    wire go = exec_i && !busy_o;
    wire [3:0] hi = opcode_i[7:4];
    wire rng = opcode_i[3:0] >= 4'h2 && opcode_i[3:0] <= 4'h9;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_trap_pc;
        go && opcode_i == 8'hF2 |=> busy_o [*5] ##1 pc_we_o && pc_data_o == {8'h00, $past(vector_pc_i, 6)};
    endproperty
    a_trap_pc: assert property (p_trap_pc)
        else $error("trap reload wrong");
    property p_trap_stack;
        go && opcode_i == 8'hF2 |=> stack_data_o == $past(pc_i[15:8]) ##2 sp_we_o && sp_data_o == $past(sp_i, 3) - 8'h03;
    endproperty
    a_trap_stack: assert property (p_trap_stack)
        else $error("trap stack wrong");
    property p_sub;
        go && hi == 4'h2 && rng |=> dst_we_o && flags_o[3] && dst_data_o == $past(dst_i) - $past(src_i);
    endproperty
    a_sub: assert property (p_sub)
        else $error("subtract wrong");
    property p_xor;
        go && hi == 4'hB && rng |=> dst_data_o == ($past(dst_i) ^ $past(src_i)) && flags_o[7] == $past(flags_o[7]) && !flags_o[4];
    endproperty
    a_xor: assert property (p_xor)
        else $error("xor wrong");
    property p_mask;
        go && (hi == 4'h6 || hi == 4'h7) && rng |=> !dst_we_o && !flags_o[4] && flags_o[7] == $past(flags_o[7]);
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask test wrong");
    property p_keep;
        go && (opcode_i == 8'h5F || opcode_i == 8'h6F) |=> flags_o == $past(flags_o) && (wdog_refresh_o ^ stop_o);
    endproperty
    a_keep: assert property (p_keep)
        else $error("watchdog or stop wrong");
    property p_user;
        go && !interrupt_return_op_i && !user_set_i |=> flags_o[1:0] == $past(flags_o[1:0]);
    endproperty
    a_user: assert property (p_user)
        else $error("user bits moved");
    property p_cond;
        cond_o == flags_o[3'h7 - cond_sel_i];
    endproperty
    a_cond: assert property (p_cond)
        else $error("jump condition wrong");
    property p_interrupt_return_op;
        interrupt_return_op_i |=> flags_o == $past(interrupt_return_op_flags_i);
    endproperty
    a_interrupt_return_op: assert property (p_interrupt_return_op)
        else $error("flags not restored");
    property p_push;
        (irq_entry_i || illegal_trap_i) && !exec_i && !busy_o |=> stack_we_o && stack_data_o == $past(flags_o) && stack_addr_o == $past(sp_i) - 8'h01;
    endproperty
    a_push: assert property (p_push)
        else $error("flags push wrong");
endmodule
`default_nettype wire

// ===== testbench/cftail_exec_bench.sv
// Self-checking bench for the flags and tail-opcode execute block
`timescale 1ns/100ps
`default_nettype none
module cftail_exec_bench;
    // Stimulus and observed outputs
    logic clk_i, nrst_i, exec_i, irq_entry_i, illegal_trap_i, interrupt_return_op_i, user_set_i;
    logic [7:0] opcode_i, opcode2_i, dst_i, src_i, vector_pc_i, sp_i, interrupt_return_op_flags_i, user_val_i;
    logic [15:0] pc_i;
    logic [1:0] cond_sel_i;
    wire dst_we_o, bank_we_o, stop_o, wdog_refresh_o, stack_we_o, sp_we_o, pc_we_o, busy_o, cond_o;
    wire [7:0] dst_data_o, bank_data_o, stack_addr_o, stack_data_o, sp_data_o, flags_o;
    wire [15:0] pc_data_o;
    int err_total, check_count;
    cftail_exec dut_u (.*);
    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // One-cycle issue; outputs are settled on return
    task automatic issue(input logic [7:0] op, input logic [7:0] op2, input logic [7:0] d, input logic [7:0] s);
        @(negedge clk_i);
        {opcode_i, opcode2_i, dst_i, src_i} = {op, op2, d, s};
        exec_i = 1'b1;
        @(negedge clk_i);
        exec_i = 1'b0;
    endtask
    // User bits survive a reset, status bits clear
    task automatic t_reset;
        user_val_i = 8'h02;
        user_set_i = 1'b1;
        @(negedge clk_i);
        user_set_i = 1'b0;
        nrst_i = 1'b0;
        @(negedge clk_i);
        nrst_i = 1'b1;
        chk(flags_o, 16'h02);
    endtask
    // Subtract, exclusive-or and mask tests over every code
    task automatic t_alu;
        for (int i = 0; i < 8; i++)
        begin
            issue(8'h22 + i[7:0], 8'h00, 8'h10, 8'h20);
            chk({dst_we_o, dst_data_o}, 16'h1F0);
            chk(flags_o, 16'hAA);
            issue(8'hB2 + i[7:0], 8'h00, 8'h5A, 8'h5A);
            chk(dst_data_o, 16'h00);
            chk(flags_o, 16'hCA);
            issue(8'h72 + i[7:0], 8'h00, 8'h0F, 8'hF0);
            chk({dst_we_o, flags_o}, 16'hCA);
            issue(8'h62 + i[7:0], 8'h00, 8'h0F, 8'hF0);
            chk({dst_we_o, flags_o}, 16'hAA);
        end
    endtask
    // Both shifts, register and indirect
    task automatic t_shift;
        for (int j = 0; j < 2; j++)
        begin
            issue(8'hD0 + j[7:0], 8'h00, 8'h81, 8'h00);
            chk({dst_data_o, flags_o}, 16'hC0AA);
            issue(8'h1F, 8'hC0 + j[7:0], 8'h81, 8'h00);
            chk({dst_data_o, flags_o}, 16'h408A);
        end
    endtask
    // Set carry, watchdog, stop, bank load and jump conditions
    task automatic t_misc;
        issue(8'h22, 8'h00, 8'h20, 8'h10);
        issue(8'hDF, 8'h00, 8'h00, 8'h00);
        chk(flags_o, 16'h8A);
        issue(8'h5F, 8'h00, 8'h00, 8'h00);
        chk({wdog_refresh_o, flags_o}, 16'h18A);
        issue(8'h6F, 8'h00, 8'h00, 8'h00);
        chk({stop_o, flags_o}, 16'h18A);
        issue(8'h01, 8'h00, 8'h00, 8'h33);
        chk({bank_we_o, bank_data_o}, 16'h133);
        for (int i = 0; i < 4; i++)
        begin
            // Select changes on the falling edge, mux is read just after
            @(negedge clk_i);
            cond_sel_i = i[1:0];
            #1 chk(cond_o, i == 0);
        end
        // Back on a falling edge before the next scenario drives inputs
        @(negedge clk_i);
    endtask
    // Software trap: stack writes, pointer and reload timing
    task automatic t_trap;
        int n;
        logic [7:0] s;
        logic [15:0] q[$];
        sp_i = 8'h80;
        pc_i = 16'h1234;
        vector_pc_i = 8'h56;
        issue(8'hF2, 8'h00, 8'h00, 8'h00);
        for (n = 1; n < 12 && pc_we_o !== 1'b1; n++)
        begin
            if (stack_we_o === 1'b1)
                q.push_back({stack_addr_o, stack_data_o});
            if (sp_we_o === 1'b1)
                s = sp_data_o;
            @(negedge clk_i);
        end
        chk(n, 6);
        if (n == 12)
            finish_test();
        chk(pc_data_o, 16'h0056);
        chk(s, 16'h7D);
        chk(q[0], 16'h7F12);
        chk(q[1], 16'h7E34);
        chk(q[2], 16'h7D8A);
    endtask
    // Interrupt and illegal-trap pushes, then flags restore
    task automatic t_push;
        for (int i = 0; i < 2; i++)
        begin
            irq_entry_i = (i == 0);
            illegal_trap_i = (i == 1);
            @(negedge clk_i);
            {irq_entry_i, illegal_trap_i} = 2'b00;
            chk({stack_we_o, stack_data_o}, 16'h18A);
            chk(stack_addr_o, 16'h7F);
            chk({sp_we_o, sp_data_o}, 16'h17F);
        end
        interrupt_return_op_flags_i = 8'h57;
        interrupt_return_op_i = 1'b1;
        @(negedge clk_i);
        interrupt_return_op_i = 1'b0;
        chk(flags_o, 16'h57);
    endtask
    // Clock generation
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Main sequence
    initial
    begin
        {nrst_i, exec_i, irq_entry_i, illegal_trap_i, interrupt_return_op_i, user_set_i} = 6'h00;
        {opcode_i, opcode2_i, dst_i, src_i, vector_pc_i, sp_i, interrupt_return_op_flags_i, user_val_i} = 64'h0;
        pc_i = 16'h0000;
        cond_sel_i = 2'h0;
        repeat (12) @(negedge clk_i);
        nrst_i = 1'b1;
        t_reset();
        t_alu();
        t_shift();
        t_misc();
        t_trap();
        t_push();
        finish_test();
    end
endmodule
bind cftail_exec cftail_exec_monitor mon_u (.*);
`default_nettype wire
